// >>> mms_link_rx.v
// two-flop synchroniser with edge detection for one link or trigger pin
`timescale 1ns/1ps
module mms_link_rx
(
    // clock and reset
    input  wire mclk,
    input  wire reset_n,
    // pin side
    input  wire pin_i,
    // synchronised side
    output wire level_o,
    output wire rise_o,
    output wire edge_o
);
    reg sync1_q;
    reg sync2_q;
    reg last_q;

    // first flop feeds only the second; edges come from the later pair
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    assign level_o = sync2_q;
    assign rise_o  = sync2_q & ~last_q;
    assign edge_o  = sync2_q ^ last_q;
endmodule // mms_link_rx

// >>> mms_peer.sv
// peer master module standing on the far side of both links
`timescale 1ns/1ps
module mms_peer
(
    // frame request from the bench
    input  wire  go,
    // link lines driven by the peer
    output logic refclk,
    output logic trig,
    output logic otrig
);
    // link clock runs only inside a frame, off phase with mclk
    initial
    begin
        refclk = 1'b0;
        #3;
        forever
        begin
            #40;
            if (go)
                refclk = ~refclk;
        end
    end
    // start lines follow the frame; the bench arms slaves first, except in the late-arm test
    assign trig  = go;
    assign otrig = go;
endmodule // mms_peer

// >>> mms_sync_link.v
// multi-module synchronisation of input and output conversion subsystems over two links
//
// Operation
// - each subsystem holds master, slave or none mode; none after reset.
// - a master drives trigger lines and the reference clock onto the link.
// - a slave starts from the link trigger and ignores its local start source.
// - mode none times conversions from the local 48 MHz reference, link unused.
// - mode settings stay until rewritten; only reset clears them.
// - a config with one subsystem master and the other slave is refused, error flagged.
// - output subsystem takes its reference clock from the input-side link.
// - input and output align per subsystem; relative timing repeats run to run.
// - master and armed slaves start together within one conversion period.
// - after reference trigger every module captures its own post-trigger scan count.
// - a slave armed after the master started never starts, keeps waiting.
// - stopping an input slave that still waits completes after about 20 seconds.
// - stopping the master does not stop slaves without a reference trigger.
`timescale 1ns/1ps
`include "mms_sync_map.vh"
module mms_sync_link
#(
    parameter [63:0] STOP_WAIT_CYC = `MMS_STOP_WAIT_S * `MMS_MCLK_HZ
)
(
    // clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // local trigger inputs
    input  wire        ext_trig_i,
    input  wire [1:0]  thresh_hit,
    // input-side link
    input  wire        in_link_refclk_i,
    output reg         in_link_refclk_o,
    output wire        in_link_refclk_oe,
    input  wire        in_link_trig_i,
    output wire        in_link_trig_o,
    output wire        in_link_trig_oe,
    input  wire        in_link_rtrg_i,
    output wire        in_link_rtrg_o,
    output wire        in_link_rtrg_oe,
    // output-side link
    input  wire        output_side_sync_link_trig_i,
    output wire        output_side_sync_link_trig_o,
    output wire        output_side_sync_link_trig_oe,
    input  wire        output_side_sync_link_rtrg_i,
    output wire        output_side_sync_link_rtrg_o,
    output wire        output_side_sync_link_rtrg_oe,
    // conversion timing to the converters
    output wire [1:0]  conv_tick,
    output wire [1:0]  running
);
    // subsystem states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ARMED = 3'h1;
    localparam [2:0] ST_RUN   = 3'h2;
    localparam [2:0] ST_POST  = 3'h3;
    localparam [2:0] ST_STOPW = 3'h4;
    localparam [2:0] ST_DONE  = 3'h5;

    // true when one subsystem is master and the other slave
    function cfg_bad;
        input [3:0] cfg;
        begin
            cfg_bad = ((cfg[1:0] == `MMS_MODE_MASTER) && (cfg[3:2] == `MMS_MODE_SLAVE)) ||
                      ((cfg[1:0] == `MMS_MODE_SLAVE) && (cfg[3:2] == `MMS_MODE_MASTER));
        end
    endfunction

    // divider wrap test; a divisor of zero behaves as one
    function div_wrap;
        input [15:0] cnt;
        input [15:0] div;
        begin
            div_wrap = ({1'b0, cnt} + 17'd1 >= {1'b0, div});
        end
    endfunction

    wire wr_en = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;

    // unmapped offsets answer with an error; no wait states
    reg mapped;
    always @*
    begin
        case (paddr)
            `MMS_ADDR_CFG, `MMS_ADDR_CTRL0, `MMS_ADDR_CTRL1, `MMS_ADDR_DIV0,
            `MMS_ADDR_DIV1, `MMS_ADDR_POST0, `MMS_ADDR_POST1, `MMS_ADDR_STAT,
            `MMS_ADDR_CNT0, `MMS_ADDR_CNT1: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // synchronised pins
    wire ext_lvl;
    wire ext_rise;
    wire refclk_edge;
    wire [1:0] ltrig_rise;
    wire [1:0] lrtrg_rise;
    wire [1:0] link_trig_pin = {output_side_sync_link_trig_i, in_link_trig_i};
    wire [1:0] link_rtrg_pin = {output_side_sync_link_rtrg_i, in_link_rtrg_i};

    mms_link_rx u_ext_rx
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pin_i   (ext_trig_i),
        .level_o (ext_lvl),
        .rise_o  (ext_rise),
        .edge_o  ()
    );

    // reference clock line from the input-side link, used by both subsystems
    mms_link_rx u_refclk_rx
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pin_i   (in_link_refclk_i),
        .level_o (),
        .rise_o  (),
        .edge_o  (refclk_edge)
    );

    // sync mode config, kept until rewritten
    reg [3:0] cfg_q;
    reg       err_q;
    wire      cfg_wr = wr_en & (paddr == `MMS_ADDR_CFG);
    wire      cfg_rej = cfg_wr & cfg_bad(pwdata[3:0]);
    wire      err_clr = wr_en & (paddr == `MMS_ADDR_STAT) & pwdata[`MMS_STAT_ERR];

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_q <= `MMS_CFG_RESET;
            err_q <= 1'b0;
        end
        else
        begin
            if (cfg_wr && !cfg_rej)
                cfg_q <= pwdata[3:0];
            // a refused write sets the flag and beats a clear in the same cycle
            if (cfg_rej)
                err_q <= 1'b1;
            else if (err_clr)
                err_q <= 1'b0;
        end
    end

    // local 48 MHz reference as a fractional enable from the 125 MHz clock
    reg  [7:0] acc_q;
    wire [7:0] acc_sum = acc_q + `MMS_REF_MHZ;
    wire       local_tick = (acc_sum >= `MMS_MCLK_MHZ);
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            acc_q <= 8'h00;
        else if (local_tick)
            acc_q <= acc_sum - `MMS_MCLK_MHZ;
        else
            acc_q <= acc_sum;
    end

    wire any_master = (cfg_q[1:0] == `MMS_MODE_MASTER) | (cfg_q[3:2] == `MMS_MODE_MASTER);

    // master puts the reference onto the link as a toggling clock line
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            in_link_refclk_o <= 1'b0;
        else if (any_master && local_tick)
            in_link_refclk_o <= ~in_link_refclk_o;
    end
    assign in_link_refclk_oe = any_master;

    // flattened per-subsystem values for the read mux and pins
    wire [5:0]  st_all;
    wire [15:0] ctrl_all;
    wire [31:0] div_all;
    wire [47:0] post_all;
    wire [63:0] cnt_all;
    wire [1:0]  trig_o_all;
    wire [1:0]  rtrg_o_all;
    wire [1:0]  oe_all;

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : g_sub
            localparam [7:0] A_CTRL = (k == 0) ? `MMS_ADDR_CTRL0 : `MMS_ADDR_CTRL1;
            localparam [7:0] A_DIV  = (k == 0) ? `MMS_ADDR_DIV0  : `MMS_ADDR_DIV1;
            localparam [7:0] A_POST = (k == 0) ? `MMS_ADDR_POST0 : `MMS_ADDR_POST1;

            wire [1:0] mode = cfg_q[2*k+1:2*k];
            wire       is_slave  = (mode == `MMS_MODE_SLAVE);
            wire       is_master = (mode == `MMS_MODE_MASTER);

            // per-link trigger receivers
            wire trig_rise;
            wire rtrg_rise;
            mms_link_rx u_trig_rx
            (
                .mclk    (mclk),
                .reset_n (reset_n),
                .pin_i   (link_trig_pin[k]),
                .level_o (),
                .rise_o  (trig_rise),
                .edge_o  ()
            );
            mms_link_rx u_rtrg_rx
            (
                .mclk    (mclk),
                .reset_n (reset_n),
                .pin_i   (link_rtrg_pin[k]),
                .level_o (),
                .rise_o  (rtrg_rise),
                .edge_o  ()
            );

            reg  [7:0]  ctrl_q;
            reg  [15:0] div_q;
            reg  [23:0] post_q;
            reg  [2:0]  state_q;
            reg  [15:0] divcnt_q;
            reg  [23:0] remain_q;
            reg  [31:0] stopcnt_q;
            reg  [31:0] count_q;
            reg         conv_q;

            wire ctrl_wr = wr_en & (paddr == A_CTRL);
            wire arm_cmd = ctrl_wr & pwdata[`MMS_CTRL_ARM];
            wire stop_cmd = ctrl_wr & pwdata[`MMS_CTRL_STOP];
            wire sw_cmd  = ctrl_wr & pwdata[`MMS_CTRL_SWTRIG];

            // slaves time from the link clock, others from the local reference
            wire ref_tick = is_slave ? refclk_edge : local_tick;

            // local start source, replaced by the link trigger in slave mode
            reg local_start;
            always @*
            begin
                case (ctrl_q[`MMS_CTRL_SRC_LO+1:`MMS_CTRL_SRC_LO])
                    `MMS_SRC_SW:     local_start = sw_cmd;
                    `MMS_SRC_EXT:    local_start = ext_rise;
                    `MMS_SRC_THRESH: local_start = thresh_hit[k];
                    default:         local_start = 1'b0;
                endcase
            end
            // an already-high link trigger gives no rising edge, so a late slave waits
            wire start_ev = is_slave ? trig_rise : local_start;

            wire local_ref = ctrl_q[`MMS_CTRL_REFSRC] ? thresh_hit[k] : ext_rise;
            wire ref_ev = ctrl_q[`MMS_CTRL_REFEN] & (is_slave ? rtrg_rise : local_ref);
            wire wrap = ref_tick & div_wrap(divcnt_q, div_q);

            // register writes
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    ctrl_q <= 8'h00;
                    div_q  <= `MMS_DIV_RESET;
                    post_q <= `MMS_POST_RESET;
                end
                else
                begin
                    if (ctrl_wr)
                        ctrl_q <= {pwdata[7:4], 4'h0};
                    if (wr_en && paddr == A_DIV)
                        div_q <= pwdata[15:0];
                    if (wr_en && paddr == A_POST)
                        post_q <= pwdata[23:0];
                end
            end

            // acquisition sequence: arm, start, run, optional post-trigger count
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    state_q   <= ST_IDLE;
                    divcnt_q  <= 16'h0000;
                    remain_q  <= 24'h000000;
                    stopcnt_q <= 32'h00000000;
                    count_q   <= 32'h00000000;
                    conv_q    <= 1'b0;
                end
                else
                begin
                    conv_q <= 1'b0;
                    case (state_q)
                        ST_IDLE, ST_DONE:
                        begin
                            if (stop_cmd)
                                state_q <= ST_IDLE;
                            else if (arm_cmd)
                            begin
                                state_q <= ST_ARMED;
                                count_q <= 32'h00000000;
                            end
                        end
                        ST_ARMED:
                        begin
                            if (stop_cmd && is_slave && k == 0)
                            begin
                                // a waiting input slave only gives up after the long wait
                                state_q   <= ST_STOPW;
                                stopcnt_q <= 32'h00000000;
                            end
                            else if (stop_cmd)
                                state_q <= ST_IDLE;
                            else if (start_ev)
                            begin
                                // divider restarts at the trigger so all modules line up
                                state_q  <= ST_RUN;
                                divcnt_q <= 16'h0000;
                            end
                        end
                        ST_RUN, ST_POST:
                        begin
                            if (ref_tick)
                                divcnt_q <= wrap ? 16'h0000 : divcnt_q + 16'h0001;
                            if (wrap)
                            begin
                                conv_q  <= 1'b1;
                                count_q <= count_q + 32'h00000001;
                            end
                            // the link trigger falling is ignored; a run ends on a stop or on the reference trigger once its post-trigger count is done
                            if (stop_cmd)
                                state_q <= ST_IDLE;
                            else if (state_q == ST_RUN && ref_ev)
                            begin
                                if (post_q == 24'h000000)
                                    state_q <= ST_DONE;
                                else
                                begin
                                    state_q  <= ST_POST;
                                    remain_q <= post_q;
                                end
                            end
                            else if (state_q == ST_POST && wrap)
                            begin
                                remain_q <= remain_q - 24'h000001;
                                if (remain_q == 24'h000001)
                                    state_q <= ST_DONE;
                            end
                        end
                        ST_STOPW:
                        begin
                            if (stopcnt_q + 32'h00000001 >= STOP_WAIT_CYC[31:0])
                                state_q <= ST_IDLE;
                            else
                                stopcnt_q <= stopcnt_q + 32'h00000001;
                        end
                        default:
                            state_q <= ST_IDLE;
                    endcase
                end
            end

            assign st_all[3*k+2:3*k]     = state_q;
            assign ctrl_all[8*k+7:8*k]   = ctrl_q;
            assign div_all[16*k+15:16*k] = div_q;
            assign post_all[24*k+23:24*k] = post_q;
            assign cnt_all[32*k+31:32*k] = count_q;
            assign conv_tick[k]          = conv_q;
            assign running[k]            = (state_q == ST_RUN) | (state_q == ST_POST);
            // master shows run and reference-trigger state as levels on its link
            assign trig_o_all[k] = (state_q == ST_RUN) | (state_q == ST_POST);
            assign rtrg_o_all[k] = (state_q == ST_POST) | (state_q == ST_DONE);
            assign oe_all[k]     = is_master;
        end
    endgenerate

    assign in_link_trig_o                = trig_o_all[0];
    assign in_link_trig_oe               = oe_all[0];
    assign in_link_rtrg_o                = rtrg_o_all[0];
    assign in_link_rtrg_oe               = oe_all[0];
    assign output_side_sync_link_trig_o  = trig_o_all[1];
    assign output_side_sync_link_trig_oe = oe_all[1];
    assign output_side_sync_link_rtrg_o  = rtrg_o_all[1];
    assign output_side_sync_link_rtrg_oe = oe_all[1];

    // read data is captured in the setup phase so it stands for the access phase
    reg [31:0] rd_d;
    always @*
    begin
        case (paddr)
            `MMS_ADDR_CFG:   rd_d = {28'h0000000, cfg_q};
            `MMS_ADDR_CTRL0: rd_d = {24'h000000, ctrl_all[7:0]};
            `MMS_ADDR_CTRL1: rd_d = {24'h000000, ctrl_all[15:8]};
            `MMS_ADDR_DIV0:  rd_d = {16'h0000, div_all[15:0]};
            `MMS_ADDR_DIV1:  rd_d = {16'h0000, div_all[31:16]};
            `MMS_ADDR_POST0: rd_d = {8'h00, post_all[23:0]};
            `MMS_ADDR_POST1: rd_d = {8'h00, post_all[47:24]};
            `MMS_ADDR_STAT:  rd_d = {21'h000000, st_all[5:3] == ST_STOPW,
                                     st_all[2:0] == ST_STOPW, err_q,
                                     1'b0, st_all[5:3], 1'b0, st_all[2:0]};
            `MMS_ADDR_CNT0:  rd_d = cnt_all[31:0];
            `MMS_ADDR_CNT1:  rd_d = cnt_all[63:32];
            default:         rd_d = 32'h00000000;
        endcase
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= rd_d;
    end

    // ext_lvl kept for visibility of the pin level in simulation waveforms only
    wire unused_ext = ext_lvl;
endmodule // mms_sync_link

// >>> mms_sync_link_sva.sv
// checker for the sync link block: link drive and conversion timing
`timescale 1ns/1ps
module mms_sync_link_sva
(
    // clock and reset
    input wire       mclk,
    input wire       reset_n,
    // link drive
    input wire       in_link_refclk_o,
    input wire       in_link_refclk_oe,
    input wire       in_link_trig_o,
    input wire       in_link_trig_oe,
    input wire       in_link_rtrg_o,
    input wire       in_link_rtrg_oe,
    input wire       output_side_sync_link_trig_o,
    // conversion side
    input wire [1:0] conv_tick,
    input wire [1:0] running
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // a run start and the first conversion that must follow it
    sequence s_start;
        $rose(running[0]);
    endsequence
    sequence s_tick;
        ##[1:40] conv_tick[0];
    endsequence
    a_run_ticks: assert property (s_start |-> s_tick)
        else $error("no conversion after start");
    a_clock_with_trig: assert property (in_link_trig_oe |-> in_link_refclk_oe)
        else $error("master trigger without clock drive");
    a_rtrg_with_trig: assert property (in_link_trig_oe |-> in_link_rtrg_oe)
        else $error("master trigger without reference drive");
    a_trig_runs: assert property (in_link_trig_o && in_link_trig_oe |-> running[0])
        else $error("start line high while input idle");
    a_out_trig_runs: assert property (output_side_sync_link_trig_o |-> running[1])
        else $error("output start line high while idle");
    a_tick_single: assert property (conv_tick[0] |=> !conv_tick[0])
        else $error("conversion pulse longer than one cycle");
    // the clock line must not move once no subsystem is master
    a_clock_idle: assert property (!in_link_refclk_oe && !$past(in_link_refclk_oe)
        |-> $stable(in_link_refclk_o))
        else $error("link clock moves while not master");
    a_ref_after_run: assert property ($rose(in_link_rtrg_o) |-> $past(running[0]))
        else $error("reference line without a run");
endmodule // mms_sync_link_sva
bind mms_sync_link mms_sync_link_sva mms_sync_link_sva_inst (.mclk, .reset_n,
    .in_link_refclk_o, .in_link_refclk_oe, .in_link_trig_o, .in_link_trig_oe,
    .in_link_rtrg_o, .in_link_rtrg_oe, .output_side_sync_link_trig_o, .conv_tick, .running);

// >>> mms_sync_link_tb_top.sv
// testbench for the sync link block: apb tasks and link scenarios
`timescale 1ns/1ps
`include "mms_sync_map.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module mms_sync_link_tb_top;
    logic        mclk, reset_n, psel, penable, pwrite, go, ev, ext, rt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rv;
    logic [1:0]  thresh_hit;
    int          mismatches, compares, n;
    wire  [31:0] prdata;
    wire  [1:0]  conv_tick, running;
    wire pready, pslverr, in_link_refclk_o, in_link_refclk_oe, in_link_trig_o, p_ref;
    wire in_link_trig_oe, in_link_rtrg_o, in_link_rtrg_oe, p_trg, p_otrg;
    wire output_side_sync_link_trig_o, output_side_sync_link_trig_oe;
    wire output_side_sync_link_rtrg_o, output_side_sync_link_rtrg_oe;
    // shared link lines: the local driver wins while enabled
    wire ref_w  = in_link_refclk_oe ? in_link_refclk_o : p_ref;
    wire trg_w  = in_link_trig_oe ? in_link_trig_o : p_trg;
    wire otrg_w = output_side_sync_link_trig_oe ? output_side_sync_link_trig_o : p_otrg;

    mms_sync_link #(.STOP_WAIT_CYC(64'd20)) mms_sync_link_inst (.mclk, .reset_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trig_i(ext),
        .thresh_hit, .in_link_refclk_i(ref_w), .in_link_refclk_o, .in_link_refclk_oe,
        .in_link_trig_i(trg_w), .in_link_trig_o, .in_link_trig_oe, .in_link_rtrg_i(rt),
        .in_link_rtrg_o, .in_link_rtrg_oe, .output_side_sync_link_trig_i(otrg_w),
        .output_side_sync_link_trig_o, .output_side_sync_link_trig_oe,
        .output_side_sync_link_rtrg_i(1'b0), .output_side_sync_link_rtrg_o,
        .output_side_sync_link_rtrg_oe, .conv_tick, .running);
    mms_peer mms_peer_inst (.go, .refclk(p_ref), .trig(p_trg), .otrig(p_otrg));

    // free-running 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task close_out;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; an idle cycle after it keeps strobes from doubling
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
        begin
            mismatches++;
            close_out;
        end
        @(posedge mclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rv, e)
    endtask
    // bounded wait for a run state
    task wait_run(input logic [1:0] e);
        n = 0;
        while (running !== e && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        `CHK(running, e)
        if (n >= 300)
            close_out;
    endtask
    task ticks(input int s, input int b, output int c);
        c = 0;
        repeat (b)
        begin
            @(posedge mclk);
            c += (conv_tick[s] === 1'b1);
        end
    endtask

    // main sequence
    initial
    begin
        {psel, penable, pwrite, go, ext, rt} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        thresh_hit = 2'h0;
        reset_n = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`MMS_ADDR_CFG, 32'h0);
        rd(`MMS_ADDR_STAT, 32'h0);
        rd(`MMS_ADDR_DIV0, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        `CHK({ev, rv}, 33'h100000000)
        $display("test reset done");
        // master plus slave on one module, both ways round
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `MMS_ADDR_CFG, i ? 32'h6 : 32'h9);
            rd(`MMS_ADDR_CFG, 32'h0);
            rd(`MMS_ADDR_STAT, 32'h100);
            apb(1'b1, `MMS_ADDR_STAT, 32'h100);
            rd(`MMS_ADDR_STAT, 32'h0);
        end
        $display("test refuse done");
        // input master on local pacing, threshold reference ends the run
        apb(1'b1, `MMS_ADDR_CFG, 32'h1);
        `CHK({in_link_refclk_oe, in_link_trig_oe}, 2'h3)
        apb(1'b1, `MMS_ADDR_POST0, 32'h3);
        apb(1'b1, `MMS_ADDR_CTRL0, 32'hC1);
        apb(1'b1, `MMS_ADDR_CTRL0, 32'hC4);
        wait_run(2'h1);
        `CHK(in_link_trig_o, 1'b1)
        ticks(0, 125, n);
        `CHK(n, 48)
        thresh_hit <= 2'h1;
        @(posedge mclk);
        thresh_hit <= 2'h0;
        wait_run(2'h0);
        rd(`MMS_ADDR_STAT, 32'h5);
        rd(`MMS_ADDR_CFG, 32'h1);
        apb(1'b1, `MMS_ADDR_CTRL0, 32'h2);
        apb(1'b1, `MMS_ADDR_CFG, 32'h4);
        `CHK({output_side_sync_link_trig_oe, in_link_refclk_oe, in_link_trig_oe}, 3'h6)
        $display("test master done");
        // both slaves: local start requests ignored, peer supplies clock and start, bench drives the input reference line
        apb(1'b1, `MMS_ADDR_CFG, 32'hA);
        apb(1'b1, `MMS_ADDR_CTRL0, 32'h51);
        apb(1'b1, `MMS_ADDR_CTRL1, 32'h1);
        apb(1'b1, `MMS_ADDR_CTRL1, 32'h4);
        ext <= 1'b1;
        repeat (20) @(posedge mclk);
        `CHK(running, 2'h0)
        ext <= 1'b0;
        go <= 1'b1;
        wait_run(2'h3);
        ticks(0, 100, n);
        `CHK(n >= 19 && n <= 21, 1'b1)
        ticks(1, 100, n);
        `CHK(n >= 19 && n <= 21, 1'b1)
        rt <= 1'b1;
        wait_run(2'h2);
        rt <= 1'b0;
        go <= 1'b0;
        repeat (50) @(posedge mclk);
        `CHK(running, 2'h2)
        apb(1'b1, `MMS_ADDR_CTRL0, 32'h2);
        apb(1'b1, `MMS_ADDR_CTRL1, 32'h2);
        `CHK(running, 2'h0)
        $display("test slave done");
        // slave armed after the master started, then stopped while waiting
        go <= 1'b1;
        repeat (20) @(posedge mclk);
        apb(1'b1, `MMS_ADDR_CTRL0, 32'h1);
        repeat (50) @(posedge mclk);
        `CHK(running, 2'h0)
        apb(1'b1, `MMS_ADDR_CTRL0, 32'h2);
        rd(`MMS_ADDR_STAT, 32'h204);
        repeat (30) @(posedge mclk);
        rd(`MMS_ADDR_STAT, 32'h0);
        go <= 1'b0;
        $display("test late arm done");
        close_out;
    end
endmodule // mms_sync_link_tb_top

// >>> mms_sync_map.vh
// register offsets, field positions, reset values and timing counts of the sync link block
`ifndef MMS_SYNC_MAP_VH
`define MMS_SYNC_MAP_VH

// register byte offsets
`define MMS_ADDR_CFG       8'h00
`define MMS_ADDR_CTRL0     8'h04
`define MMS_ADDR_CTRL1     8'h08
`define MMS_ADDR_DIV0      8'h0C
`define MMS_ADDR_DIV1      8'h10
`define MMS_ADDR_POST0     8'h14
`define MMS_ADDR_POST1     8'h18
`define MMS_ADDR_STAT      8'h1C
`define MMS_ADDR_CNT0      8'h20
`define MMS_ADDR_CNT1      8'h24

// synchronization modes, two bits per subsystem in the config register
`define MMS_MODE_NONE      2'h0
`define MMS_MODE_MASTER    2'h1
`define MMS_MODE_SLAVE     2'h2
`define MMS_CFG_RESET      4'h0

// control register fields
`define MMS_CTRL_ARM       0
`define MMS_CTRL_STOP      1
`define MMS_CTRL_SWTRIG    2
`define MMS_CTRL_SRC_LO    4
`define MMS_CTRL_REFEN     6
`define MMS_CTRL_REFSRC    7

// start trigger sources
`define MMS_SRC_SW         2'h0
`define MMS_SRC_EXT        2'h1
`define MMS_SRC_THRESH     2'h2

// status register fields
`define MMS_STAT_ERR       8
`define MMS_STAT_STOPW0    9
`define MMS_STAT_STOPW1    10

// reset values
`define MMS_DIV_RESET      16'h0001
`define MMS_POST_RESET     24'h000000

// clock rates and timing
`define MMS_MCLK_MHZ       8'd125
`define MMS_REF_MHZ        8'd48
`define MMS_MCLK_HZ        64'd125000000
`define MMS_STOP_WAIT_S    64'd20

`endif
